// >>> pkg/ptp_bus_if.sv
`default_nettype none
interface ptp_bus_if;
  logic [31:0] ad_init;
  logic ad_init_oe;
  logic [31:0] ad_tgt;
  logic ad_tgt_oe;
  logic [3:0] cbe_n;
  logic frame_n;
  logic irdy_n;
  logic idsel;
  logic trdy_n_o;
  logic devsel_n_o;
  logic tgt_ctl_oe;
  logic par_init;
  logic par_init_oe;
  logic par_tgt;
  logic par_tgt_oe;
  // resolved wire levels (pull-ups when undriven)
  logic [31:0] ad;
  logic trdy_n;
  logic devsel_n;
  logic par;
  assign ad = ad_init_oe ? ad_init : (ad_tgt_oe ? ad_tgt : 32'hffff_ffff);
  assign trdy_n = tgt_ctl_oe ? trdy_n_o : 1'b1;
  assign devsel_n = tgt_ctl_oe ? devsel_n_o : 1'b1;
  assign par = par_init_oe ? par_init : (par_tgt_oe ? par_tgt : 1'b1);
  modport target (input ad, cbe_n, frame_n, irdy_n, idsel, par,
    output ad_tgt, ad_tgt_oe, trdy_n_o, devsel_n_o, tgt_ctl_oe, par_tgt, par_tgt_oe);
  modport initiator (input ad, trdy_n, devsel_n, par,
    output ad_init, ad_init_oe, cbe_n, frame_n, irdy_n, idsel, par_init, par_init_oe);
endinterface : ptp_bus_if
`default_nettype wire

// >>> pkg/ptp_pkg.sv
`default_nettype none
package ptp_pkg;
  // command codes (c/be during address phase)
  localparam logic [3:0] CMD_IO_READ = 4'h2;
  localparam logic [3:0] CMD_IO_WRITE = 4'h3;
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] CMD_CFG_READ = 4'ha;
  localparam logic [3:0] CMD_CFG_WRITE = 4'hb;
  // target resource window
  localparam logic [31:0] TGT_BASE = 32'h0000_1000;
  localparam logic [31:0] TGT_MASK = 32'hffff_ffc0;
  localparam int WORD_STEP = 4;
  localparam int BUF_DEPTH = 2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage : ptp_pkg
`default_nettype wire

// >>> rtl/ptp_initiator.sv
`default_nettype none
module ptp_initiator (
  input wire logic clock_in,
  input wire logic nrst_in,
  ptp_bus_if.initiator bus,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_cfg_in,
  input wire logic [31:0] req_addr_in,
  input wire logic [7:0] req_count_in,
  input wire logic [3:0] req_be_in,
  input wire logic [31:0] req_wdata_in,
  output logic req_ready_out,
  output logic wdata_take_out,
  output logic rdata_valid_out,
  output logic [31:0] rdata_out,
  output logic done_out,
  output logic abort_out
);
  typedef enum {PI_IDLE, PI_ADDR, PI_DATA, PI_TURN} ptpi_state_t;
  localparam logic [3:0] ABORT_WAIT = 4'h5;
  ptpi_state_t state, next_state;
  logic [7:0] left, next_left;
  logic [3:0] wait_cnt, next_wait_cnt;
  logic wr, next_wr;
  logic [31:0] ad_o, next_ad_o;
  logic ad_oe, next_ad_oe;
  logic [3:0] cbe, next_cbe;
  logic frame, next_frame;
  logic irdy, next_irdy;
  logic idsel, next_idsel;
  logic par_o, next_par_o;
  logic par_oe, next_par_oe;
  logic ready, next_ready, take, next_take, rv, next_rv, done, next_done, abrt, next_abrt;
  logic [31:0] rdata, next_rdata;

  // sequencer: address phase, data phases, turnaround
  always_comb begin
    next_state = state;
    next_left = left;
    next_wait_cnt = wait_cnt;
    next_wr = wr;
    next_ad_o = ad_o;
    next_ad_oe = ad_oe;
    next_cbe = cbe;
    next_frame = frame;
    next_irdy = irdy;
    next_idsel = 1'b0;
    next_par_o = ^{ad_o, cbe};
    next_par_oe = ad_oe;
    next_ready = 1'b0;
    next_take = 1'b0;
    next_rv = 1'b0;
    next_rdata = rdata;
    next_done = 1'b0;
    next_abrt = 1'b0;
    case (state)
      PI_IDLE: begin
        // start only on an idle bus
        if (req_valid_in && frame && irdy && bus.trdy_n && bus.devsel_n && !ready) begin
          next_state = PI_ADDR;
          next_ready = 1'b1;
          next_wr = req_write_in;
          next_left = req_count_in;
          next_ad_o = req_addr_in;
          next_ad_oe = 1'b1;
          next_cbe = req_cfg_in ? (req_write_in ? ptp_pkg::CMD_CFG_WRITE : ptp_pkg::CMD_CFG_READ)
                                : (req_write_in ? ptp_pkg::CMD_MEM_WRITE : ptp_pkg::CMD_MEM_READ);
          next_idsel = req_cfg_in;
          next_frame = 1'b0;
        end
      end
      PI_ADDR: begin
        // one-clock address phase, then byte enables
        next_state = PI_DATA;
        next_cbe = ~req_be_in;
        next_ad_oe = wr;
        next_ad_o = req_wdata_in;
        next_take = wr;
        next_irdy = 1'b0;
        next_wait_cnt = 4'h0;
        if (left <= 8'h01) begin
          next_frame = 1'b1;
        end
      end
      PI_DATA: begin
        if (!bus.trdy_n) begin
          if (!wr) begin
            next_rv = 1'b1;
            next_rdata = bus.ad;
          end
          next_left = left - 8'h01;
          if (frame) begin
            next_state = PI_TURN;
            next_irdy = 1'b1;
            next_ad_oe = 1'b0;
            next_done = 1'b1;
          end else begin
            next_cbe = ~req_be_in;
            next_ad_o = req_wdata_in;
            next_take = wr;
            if (left <= 8'h02) begin
              next_frame = 1'b1;
            end
          end
        end else begin
          // wait state; no claim means master abort
          next_wait_cnt = wait_cnt + 4'h1;
          if (bus.devsel_n && wait_cnt >= ABORT_WAIT) begin
            next_state = PI_TURN;
            next_frame = 1'b1;
            next_irdy = 1'b1;
            next_ad_oe = 1'b0;
            next_abrt = 1'b1;
          end
        end
      end
      PI_TURN: begin
        next_state = PI_IDLE;
        next_cbe = 4'hf;
        next_irdy = 1'b1;
      end
      default: next_state = PI_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= PI_IDLE;
      left <= 8'h00;
      wait_cnt <= 4'h0;
      wr <= 1'b0;
      ad_o <= ptp_pkg::RST_WORD;
      ad_oe <= 1'b0;
      cbe <= 4'hf;
      frame <= 1'b1;
      irdy <= 1'b1;
      idsel <= 1'b0;
      par_o <= 1'b0;
      par_oe <= 1'b0;
      ready <= 1'b0;
      take <= 1'b0;
      rv <= 1'b0;
      rdata <= ptp_pkg::RST_WORD;
      done <= 1'b0;
      abrt <= 1'b0;
    end else begin
      state <= next_state;
      left <= next_left;
      wait_cnt <= next_wait_cnt;
      wr <= next_wr;
      ad_o <= next_ad_o;
      ad_oe <= next_ad_oe;
      cbe <= next_cbe;
      frame <= next_frame;
      irdy <= next_irdy;
      idsel <= next_idsel;
      par_o <= next_par_o;
      par_oe <= next_par_oe;
      ready <= next_ready;
      take <= next_take;
      rv <= next_rv;
      rdata <= next_rdata;
      done <= next_done;
      abrt <= next_abrt;
    end
  end

  assign bus.ad_init = ad_o;
  assign bus.ad_init_oe = ad_oe;
  assign bus.cbe_n = cbe;
  assign bus.frame_n = frame;
  assign bus.irdy_n = irdy;
  assign bus.idsel = idsel;
  assign bus.par_init = par_o;
  assign bus.par_init_oe = par_oe;
  assign req_ready_out = ready;
  assign wdata_take_out = take;
  assign rdata_valid_out = rv;
  assign rdata_out = rdata;
  assign done_out = done;
  assign abort_out = abrt;
endmodule : ptp_initiator
`default_nettype wire

// >>> rtl/ptp_target.sv
`default_nettype none
// What this block does
// - address phase lasts exactly one clock
// - initiator drives address, command, frame together
// - latch address and command at frame
// - claim own addresses by asserting devsel
// - later clocks carry data and byte enables
// - all byte lanes are transferred, byte enables passed along
// - each missing ready adds a wait clock
// - word moves when irdy and trdy low
// - target increments burst address itself
// - initiator deasserts frame on last phase
// - after last transfer release trdy, devsel
// - bus idle when all four high
// - even parity one clock after phase
// - idsel selects configuration cycles
// - reset clears state, floats data lines
module ptp_target #(
  parameter int WIDTH = 32,
  parameter int DEPTH = ptp_pkg::BUF_DEPTH
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  ptp_bus_if.target bus,
  output logic wr_valid_out,
  output logic [31:0] wr_addr_out,
  output logic [WIDTH-1:0] wr_data_out,
  output logic [3:0] wr_be_out,
  output logic wr_cfg_out,
  input wire logic wr_ready_in,
  output logic [31:0] rd_addr_out,
  output logic rd_cfg_out,
  output logic rd_req_out,
  input wire logic [31:0] rd_data_in,
  output logic busy_out
);
  typedef enum {PT_IDLE, PT_DATA, PT_TURN} ptpt_state_t;
  localparam int AW = $clog2(DEPTH);

  // address match used for both memory and io decode
  function automatic logic ptpt_hit(input logic [31:0] a, input logic [3:0] c, input logic sel);
    if (c == ptp_pkg::CMD_CFG_READ || c == ptp_pkg::CMD_CFG_WRITE) begin
      ptpt_hit = sel;
    end else if (c == ptp_pkg::CMD_MEM_READ || c == ptp_pkg::CMD_MEM_WRITE ||
                 c == ptp_pkg::CMD_IO_READ || c == ptp_pkg::CMD_IO_WRITE) begin
      ptpt_hit = (a & ptp_pkg::TGT_MASK) == ptp_pkg::TGT_BASE;
    end else begin
      ptpt_hit = 1'b0;
    end
  endfunction : ptpt_hit

  ptpt_state_t state, next_state;
  logic frame_q, next_frame_q;
  logic [31:0] addr, next_addr;
  logic [3:0] cmd, next_cmd;
  logic cfg, next_cfg;
  logic devsel, next_devsel, trdy, next_trdy, ctl_oe, next_ctl_oe;
  logic [31:0] ad_o, next_ad_o;
  logic ad_oe, next_ad_oe;
  logic par_o, next_par_o, par_oe, next_par_oe;
  logic rreq, next_rreq;
  logic [WIDTH+37-1:0] mem [DEPTH];
  logic [AW:0] wp, next_wp, rp, next_rp;
  logic [WIDTH+37-1:0] head;
  logic ovalid, next_ovalid;
  logic [WIDTH+37-1:0] oword, next_oword;
  logic is_wr, buf_full, buf_empty, xfer, push, pop;

  assign is_wr = cmd[0];
  assign buf_full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign buf_empty = (wp == rp);
  assign xfer = !bus.irdy_n && !trdy;
  assign push = xfer && is_wr && (state == PT_DATA);
  assign pop = !buf_empty && (!ovalid || wr_ready_in);
  assign head = mem[rp[AW-1:0]];

  // transaction sequencer
  always_comb begin
    next_state = state;
    next_frame_q = bus.frame_n;
    next_addr = addr;
    next_cmd = cmd;
    next_cfg = cfg;
    next_devsel = devsel;
    next_trdy = trdy;
    next_ctl_oe = ctl_oe;
    next_ad_o = ad_o;
    next_ad_oe = 1'b0;
    next_rreq = 1'b0;
    // parity covers what we drove last clock
    next_par_o = ^{ad_o, bus.cbe_n};
    next_par_oe = ad_oe;
    case (state)
      PT_IDLE: begin
        next_ctl_oe = 1'b0;
        // falling frame marks the address phase
        if (frame_q && !bus.frame_n) begin
          next_addr = bus.ad;
          next_cmd = bus.cbe_n;
          next_cfg = bus.cbe_n == ptp_pkg::CMD_CFG_READ || bus.cbe_n == ptp_pkg::CMD_CFG_WRITE;
          if (ptpt_hit(bus.ad, bus.cbe_n, bus.idsel)) begin
            next_state = PT_DATA;
            next_devsel = 1'b0;
            next_ctl_oe = 1'b1;
            next_trdy = 1'b1;
            next_rreq = !bus.cbe_n[0];
          end
        end
      end
      PT_DATA: begin
        next_ad_oe = !is_wr;
        if (xfer) begin
          next_addr = addr + 32'(ptp_pkg::WORD_STEP);
          next_rreq = !is_wr && !bus.frame_n;
          if (bus.frame_n) begin
            next_state = PT_TURN;
            next_trdy = 1'b1;
            next_devsel = 1'b1;
            next_ad_oe = 1'b0;
          end else begin
            next_trdy = 1'b1; // one wait clock to drain, two to refetch
          end
        end else begin
          // ready when read data fetched or buffer has room
          next_trdy = is_wr ? buf_full : rreq;
          if (!is_wr && !rreq) begin
            next_ad_o = rd_data_in;
            next_trdy = 1'b0;
          end
        end
      end
      PT_TURN: begin
        // hold released levels one clock then float
        next_ctl_oe = 1'b0;
        if (bus.frame_n && bus.irdy_n) begin
          next_state = PT_IDLE;
        end
      end
      default: next_state = PT_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= PT_IDLE;
      frame_q <= 1'b1;
      addr <= ptp_pkg::RST_WORD;
      cmd <= 4'h0;
      cfg <= 1'b0;
      devsel <= 1'b1;
      trdy <= 1'b1;
      ctl_oe <= 1'b0;
      ad_o <= ptp_pkg::RST_WORD;
      ad_oe <= 1'b0;
      par_o <= 1'b0;
      par_oe <= 1'b0;
      rreq <= 1'b0;
    end else begin
      state <= next_state;
      frame_q <= next_frame_q;
      addr <= next_addr;
      cmd <= next_cmd;
      cfg <= next_cfg;
      devsel <= next_devsel;
      trdy <= next_trdy;
      ctl_oe <= next_ctl_oe;
      ad_o <= next_ad_o;
      ad_oe <= next_ad_oe;
      par_o <= next_par_o;
      par_oe <= next_par_oe;
      rreq <= next_rreq;
    end
  end

  // two-entry write buffer; full buffer holds trdy off
  always_comb begin
    next_wp = wp + (AW+1)'(push);
    next_rp = rp + (AW+1)'(pop);
    next_ovalid = pop ? 1'b1 : (wr_ready_in ? 1'b0 : ovalid);
    next_oword = pop ? head : oword;
  end

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[wp[AW-1:0]] <= {cfg, addr, ~bus.cbe_n, bus.ad[WIDTH-1:0]};
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wp <= '0;
      rp <= '0;
      ovalid <= 1'b0;
      oword <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      ovalid <= next_ovalid;
      oword <= next_oword;
    end
  end

  assign bus.ad_tgt = ad_o;
  assign bus.ad_tgt_oe = ad_oe;
  assign bus.trdy_n_o = trdy;
  assign bus.devsel_n_o = devsel;
  assign bus.tgt_ctl_oe = ctl_oe;
  assign bus.par_tgt = par_o;
  assign bus.par_tgt_oe = par_oe;
  assign wr_valid_out = ovalid;
  assign {wr_cfg_out, wr_addr_out, wr_be_out, wr_data_out} = oword;
  assign rd_addr_out = addr;
  assign rd_cfg_out = cfg;
  assign rd_req_out = rreq;
  assign busy_out = ctl_oe;
endmodule : ptp_target
`default_nettype wire

// >>> sim/ptp_assertions.sv
`default_nettype none
module ptp_checker (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe_n,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic idsel,
  input wire logic trdy_n,
  input wire logic devsel_n,
  input wire logic ad_tgt_oe,
  input wire logic par
);
  logic is_cfg;
  logic is_mio;
  logic hit;
  // decode the way the target must: idsel for config, address window for memory and io, no hit otherwise
  assign is_cfg = (cbe_n == ptp_pkg::CMD_CFG_READ) || (cbe_n == ptp_pkg::CMD_CFG_WRITE);
  assign is_mio = (cbe_n == ptp_pkg::CMD_MEM_READ) || (cbe_n == ptp_pkg::CMD_MEM_WRITE) ||
    (cbe_n == ptp_pkg::CMD_IO_READ) || (cbe_n == ptp_pkg::CMD_IO_WRITE);
  assign hit = is_cfg ? idsel : (is_mio && ((ad & ptp_pkg::TGT_MASK) == ptp_pkg::TGT_BASE));
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);
  sequence claim_start;
    $fell(frame_n) && hit;
  endsequence
  sequence foreign_start;
    $fell(frame_n) && !hit;
  endsequence
  sequence last_xfer;
    !irdy_n && !trdy_n && frame_n;
  endsequence
  sequence bus_idle;
    frame_n && irdy_n && trdy_n && devsel_n;
  endsequence
  a_claim_own: assert property (claim_start |=> !devsel_n)
    else $error("own transaction not claimed one clock after address");
  a_ignore_foreign: assert property (foreign_start |=> devsel_n [*4])
    else $error("foreign transaction was claimed");
  a_addr_one_clock: assert property ($fell(frame_n) |=> !irdy_n)
    else $error("address phase not followed by a data phase");
  a_start_idle: assert property ($fell(frame_n) |-> $past(irdy_n) && $past(trdy_n) && $past(devsel_n))
    else $error("transaction started on a busy bus");
  a_release_last: assert property (last_xfer |=> bus_idle)
    else $error("bus not released after final transfer");
  a_trdy_one_word: assert property ((!irdy_n && !trdy_n) |=> trdy_n)
    else $error("target ready held past a transfer");
  a_trdy_claimed: assert property (!trdy_n |-> !devsel_n)
    else $error("target ready without device select");
  a_float_unclaimed: assert property ((devsel_n && $past(devsel_n)) |-> !ad_tgt_oe)
    else $error("target drives data lines while unclaimed");
  a_addr_parity: assert property ($fell(frame_n) |=> par == ^{$past(ad), $past(cbe_n)})
    else $error("address parity wrong");
endmodule : ptp_checker
`default_nettype wire

// >>> sim/tb_pci_target_transaction_port.sv
`default_nettype none
module tb_pci_target_transaction_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in, nrst_in, req_valid_in, req_write_in, req_cfg_in, req_ready_out, wdata_take_out;
  logic rdata_valid_out, done_out, abort_out, wr_valid_out, wr_cfg_out, wr_ready_in, rd_cfg_out, rd_req_out, busy_out;
  logic [31:0] req_addr_in, req_wdata_in, rdata_out, wr_addr_out, wr_data_out, rd_addr_out, rd_data_in;
  logic [7:0] req_count_in;
  logic [3:0] req_be_in, wr_be_out;
  int err_total, compares, xfers, rd_reqs;
  logic busy_seen, rd_cfg_last;
  logic [68:0] wq[$];
  logic [31:0] rq[$];
  ptp_bus_if bus ();
  ptp_initiator ptp_initiator_i (.clock_in(clock_in), .nrst_in(nrst_in), .bus(bus), .req_valid_in(req_valid_in),
    .req_write_in(req_write_in), .req_cfg_in(req_cfg_in), .req_addr_in(req_addr_in), .req_count_in(req_count_in),
    .req_be_in(req_be_in), .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out),
    .wdata_take_out(wdata_take_out), .rdata_valid_out(rdata_valid_out), .rdata_out(rdata_out),
    .done_out(done_out), .abort_out(abort_out));
  ptp_target ptp_target_i (.clock_in(clock_in), .nrst_in(nrst_in), .bus(bus), .wr_valid_out(wr_valid_out),
    .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out), .wr_be_out(wr_be_out), .wr_cfg_out(wr_cfg_out),
    .wr_ready_in(wr_ready_in), .rd_addr_out(rd_addr_out), .rd_cfg_out(rd_cfg_out), .rd_req_out(rd_req_out),
    .rd_data_in(rd_data_in), .busy_out(busy_out));
  ptp_checker ptp_checker_i (.clock_in(clock_in), .nrst_in(nrst_in), .ad(bus.ad), .cbe_n(bus.cbe_n),
    .frame_n(bus.frame_n), .irdy_n(bus.irdy_n), .idsel(bus.idsel), .trdy_n(bus.trdy_n),
    .devsel_n(bus.devsel_n), .ad_tgt_oe(bus.ad_tgt_oe), .par(bus.par));
  // read data derived from the address, so a wrong burst address shows up
  function automatic logic [31:0] rd_model(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction : rd_model
  assign rd_data_in = rd_model(rd_addr_out);
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  // collect user-side words and count bus transfers
  always @(posedge clock_in) begin
    if (wr_valid_out === 1'b1 && wr_ready_in === 1'b1) wq.push_back({wr_cfg_out, wr_addr_out, wr_be_out, wr_data_out});
    if (rdata_valid_out === 1'b1) rq.push_back(rdata_out);
    if (bus.irdy_n === 1'b0 && bus.trdy_n === 1'b0) xfers++;
    if (busy_out === 1'b1) busy_seen = 1'b1;
    if (rd_req_out === 1'b1) begin
      rd_reqs++;
      rd_cfg_last = rd_cfg_out;
    end
  end
  task automatic chk(input string what, input logic [68:0] got, input logic [68:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // one transaction from the initiator's user side, then check the bus and both user sides
  task automatic xfer(input string name, input logic wr, input logic cfg, input logic [31:0] a,
    input logic [7:0] n, input logic [3:0] be, input logic [31:0] d0, input logic ab);
    int i;
    int t;
    logic seen_ab;
    logic fin;
    i = 0;
    t = 0;
    seen_ab = 1'b0;
    fin = 1'b0;
    busy_seen = 1'b0;
    rd_reqs = 0;
    rd_cfg_last = 1'b0;
    req_write_in = wr;
    req_cfg_in = cfg;
    req_addr_in = a;
    req_count_in = n;
    req_be_in = be;
    req_wdata_in = d0;
    req_valid_in = 1'b1;
    while (!fin && t < 300) begin
      @(posedge clock_in);
      #1;
      t++;
      if (req_ready_out === 1'b1) req_valid_in = 1'b0;
      if (wdata_take_out === 1'b1) begin
        i++;
        req_wdata_in = d0 + 32'(i);
      end
      if (abort_out === 1'b1) seen_ab = 1'b1;
      fin = (done_out === 1'b1) || (abort_out === 1'b1);
    end
    req_valid_in = 1'b0;
    chk("finished", 69'(fin), 69'(1'b1));
    chk("abort", 69'(seen_ab), 69'(ab));
    t = 0;
    while (wr && !ab && wq.size() < int'(n) && t < 40) begin
      @(posedge clock_in);
      #1;
      t++;
    end
    repeat (2) @(posedge clock_in);
    #1;
    chk("idle", 69'({bus.frame_n, bus.irdy_n, bus.trdy_n, bus.devsel_n, bus.ad_tgt_oe}), 69'(5'h1e));
    chk("count", 69'(wr ? wq.size() : rq.size()), 69'(ab ? 8'h0 : n));
    chk("busy", 69'(busy_seen), 69'(!ab));
    // one fetch request per word read, none for writes or misses
    chk("rd_req", 69'(rd_reqs), 69'((wr || ab) ? 0 : int'(n)));
    if (!wr && !ab) chk("rd_cfg", 69'(rd_cfg_last), 69'(cfg));
    for (i = 0; wr && wq.size() > 0; i++) chk("wr", wq.pop_front(), {cfg, a + 32'(4 * i), be, d0 + 32'(i)});
    for (i = 0; !wr && rq.size() > 0; i++) chk("rd", 69'(rq.pop_front()), 69'(rd_model(a + 32'(4 * i))));
    $display("test %s done", name);
  endtask : xfer
  initial begin
    nrst_in = 1'b0;
    req_valid_in = 1'b0;
    req_write_in = 1'b0;
    req_cfg_in = 1'b0;
    req_addr_in = 32'h0;
    req_count_in = 8'h1;
    req_be_in = 4'hf;
    req_wdata_in = 32'h0;
    wr_ready_in = 1'b1;
    err_total = 0;
    compares = 0;
    xfers = 0;
    repeat (4) @(posedge clock_in);
    #1;
    chk("reset", 69'({bus.frame_n, bus.irdy_n, bus.trdy_n, bus.devsel_n, bus.ad_tgt_oe, bus.ad_init_oe}), 69'(6'h3c));
    nrst_in = 1'b1;
    @(posedge clock_in);
    #1;
    // memory and config reads and writes, a burst with partial enables, misses in both directions
    xfer("mem_wr", 1'b1, 1'b0, ptp_pkg::TGT_BASE + 32'h8, 8'h1, 4'hf, 32'h1122_3344, 1'b0);
    xfer("burst_wr", 1'b1, 1'b0, ptp_pkg::TGT_BASE + 32'h20, 8'h3, 4'h5, 32'ha0b0_c0d0, 1'b0);
    xfer("burst_rd", 1'b0, 1'b0, ptp_pkg::TGT_BASE + 32'h30, 8'h3, 4'hf, 32'h0, 1'b0);
    xfer("cfg_wr", 1'b1, 1'b1, 32'h0000_0010, 8'h1, 4'h3, 32'h5566_7788, 1'b0);
    xfer("cfg_rd", 1'b0, 1'b1, 32'h0000_0014, 8'h1, 4'hf, 32'h0, 1'b0);
    xfer("miss_wr", 1'b1, 1'b0, ptp_pkg::TGT_BASE + 32'h40, 8'h1, 4'hf, 32'h0bad_0001, 1'b1);
    xfer("miss_rd", 1'b0, 1'b0, 32'h0000_2000, 8'h2, 4'hf, 32'h0, 1'b1);
    // receiver stalls: buffer fills, then target must hold off with wait states
    wr_ready_in = 1'b0;
    xfers = 0;
    fork
      xfer("stall_wr", 1'b1, 1'b0, ptp_pkg::TGT_BASE + 32'h10, 8'h4, 4'hc, 32'h0f00_0000, 1'b0);
      begin
        repeat (30) @(posedge clock_in);
        #1;
        // both buffer entries plus the output register take a word before trdy is held off
        chk("held", 69'(xfers), 69'(ptp_pkg::BUF_DEPTH + 1));
        wr_ready_in = 1'b1;
      end
    join
    complete_run;
  end
  // hang guard, well beyond the hundred-odd cycles the tests need
  initial begin
    #(40 * 5000);
    err_total++;
    complete_run;
  end
endmodule : tb_pci_target_transaction_port
`default_nettype wire
